// ===== core/gfcs_pkg.sv
// package for the glitch-free clock selector: constants and carrier types
package gfcs_pkg;

  // ----------------------------------------
  // select levels and startup timing
  // ----------------------------------------
  localparam logic       SEL_FIRST      = 1'b0;   // select low picks first input
  localparam logic       SEL_DEFAULT    = 1'b1;   // undriven select reads high
  localparam int         CLK_PERIOD_NS  = 25;     // 40 MHz system clock
  localparam int         INIT_TIME_NS   = 1000;   // startup init hold time
  localparam int         INIT_CYCLES    = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         INIT_W         = 6;
  localparam logic [5:0] INIT_LAST      = 6'(INIT_CYCLES - 1);
  localparam int         DC_TIME_NS     = 2000;   // no-edge time declaring dc input
  localparam int         DC_CYCLES      = DC_TIME_NS / CLK_PERIOD_NS;
  localparam int         DC_W           = 7;
  localparam logic [6:0] DC_LAST        = 7'(DC_CYCLES - 1);

  // ----------------------------------------
  // switchover state machine
  // ----------------------------------------
  typedef enum logic [1:0] {
    GFCS_INIT    = 2'b00,
    GFCS_RUN     = 2'b01,
    GFCS_DRAIN   = 2'b10,
    GFCS_ALIGN   = 2'b11
  } gfcs_state_type;

  // differential output pair
  typedef struct packed {
    logic p;
    logic n;
  } gfcs_pair_type;

endpackage

// ===== core/gfcs_select.sv
// glitch-free two-input clock selector with two identical output pairs
// Behaviour
// - the single select input decides which clock input is forwarded.
// - select low follows first input, select high second; unselected ignored.
// - undriven select counts as high, choosing the second input.
// - both output pairs carry the same function of inputs and select.
// - with suppression on, a switchover never produces a shortened output cycle.
// - a selected input stuck at dc leaves the output held stable.
// - runt suppression state starts known, timed by the startup init pin.
// - init pin held high disables suppression; plain immediate two-to-one selection.
`timescale 1ns/1ps
`default_nettype none
module gfcs_select (
  // system
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  // clock sources, sampled
  input  wire logic                   clock_in_first,
  input  wire logic                   clock_in_second,
  // select pin and its undriven indication
  input  wire logic                   sel,
  input  wire logic                   sel_undriven,
  // startup init pin, high disables runt blocker
  input  wire logic                   startup_init_pin,
  // outputs
  output logic                        runt_blocker,
  output logic                        dc_input_guard,
  output gfcs_pkg::gfcs_pair_type     out_copy_first,
  output gfcs_pkg::gfcs_pair_type     out_copy_second
);
  import gfcs_pkg::*;

  // --------------------------------------
  // input synchronisers
  // --------------------------------------
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic [3:0] raw_in;
  logic       c0;
  logic       c1;
  logic       c0_q;
  logic       c1_q;
  logic       sel_eff;
  logic       init_hi;

  assign raw_in = {startup_init_pin, sel_undriven ? SEL_DEFAULT : sel,
                   clock_in_second, clock_in_first};

  // two flops per pin input
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= raw_in[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  assign c0      = sync_b[0];
  assign c1      = sync_b[1];
  assign sel_eff = sync_b[2];
  assign init_hi = sync_b[3];

  // previous source levels for edge detection
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      c0_q <= 1'b0;
      c1_q <= 1'b0;
    end else begin
      c0_q <= c0;
      c1_q <= c1;
    end
  end

  // --------------------------------------
  // dc detection per source
  // --------------------------------------
  logic [DC_W-1:0] idle0;
  logic [DC_W-1:0] idle1;
  logic            dead0;
  logic            dead1;

  // count cycles without an edge on each source
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      idle0 <= '0;
      idle1 <= '0;
    end else begin
      idle0 <= (c0 != c0_q) ? '0 : ((idle0 == DC_LAST) ? idle0 : idle0 + 1'b1);
      idle1 <= (c1 != c1_q) ? '0 : ((idle1 == DC_LAST) ? idle1 : idle1 + 1'b1);
    end
  end

  assign dead0 = (idle0 == DC_LAST);
  assign dead1 = (idle1 == DC_LAST);

  // --------------------------------------
  // startup init and switchover control
  // --------------------------------------
  gfcs_state_type    state;
  gfcs_state_type    next_state;
  logic [INIT_W-1:0] init_cnt;
  logic              cur;        // source currently forwarded
  logic              next_cur;
  logic              hold;       // held output level
  logic              next_hold;
  logic              cur_lvl;
  logic              new_lvl;
  logic              new_edge;
  logic              cur_dead;
  logic              new_dead;

  assign cur_lvl  = cur ? c1 : c0;
  assign new_lvl  = sel_eff ? c1 : c0;
  assign new_edge = sel_eff ? (c1 != c1_q) : (c0 != c0_q);
  assign cur_dead = cur ? dead1 : dead0;
  assign new_dead = sel_eff ? dead1 : dead0;

  // init hold counter, runs while in init state with the init pin low
  always_ff @(posedge clk) begin
    if (sys_rst || init_hi || state != GFCS_INIT)
      init_cnt <= '0;
    else if (init_cnt != INIT_LAST)
      init_cnt <= init_cnt + 1'b1;
  end

  // next state and held level
  always_comb begin
    next_state = state;
    next_cur   = cur;
    next_hold  = hold;
    case (state)
      GFCS_INIT: begin
        next_cur  = sel_eff;
        next_hold = 1'b0;
        // leave through align so the first output phase is never cut short
        if (init_cnt == INIT_LAST) next_state = GFCS_ALIGN;
      end
      GFCS_RUN: begin
        if (!cur_dead) next_hold = cur_lvl;
        if (sel_eff != cur) next_state = GFCS_DRAIN;
      end
      GFCS_DRAIN: begin
        // keep old level until the old source finishes its phase
        if (cur_dead || cur_lvl != hold) begin
          next_state = GFCS_ALIGN;
        end
      end
      GFCS_ALIGN: begin
        // wait for new source to reach held level by an edge
        if (new_edge && new_lvl == hold) begin
          next_cur   = sel_eff;
          next_state = GFCS_RUN;
        end else if (new_dead) begin
          next_cur   = sel_eff;
          next_state = GFCS_RUN;
        end
      end
      default: begin
        next_state = GFCS_INIT;
      end
    endcase
  end

  // state registers; init pin high bypasses all of it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= GFCS_INIT;
      cur   <= SEL_DEFAULT;
      hold  <= 1'b0;
    end else if (init_hi) begin
      state <= GFCS_INIT;
      cur   <= sel_eff;
      hold  <= 1'b0;
    end else begin
      state <= next_state;
      cur   <= next_cur;
      hold  <= next_hold;
    end
  end

  // --------------------------------------
  // output stage
  // --------------------------------------
  logic q;
  logic blk;
  logic guard;

  // output level from flops, both copies identical
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q     <= 1'b0;
      blk   <= 1'b0;
      guard <= 1'b0;
    end else begin
      blk   <= ~init_hi;
      guard <= cur_dead;
      if (init_hi)
        q <= (sel_eff == SEL_FIRST) ? c0 : c1;
      else if (state == GFCS_RUN && !cur_dead)
        q <= cur_lvl;
      else
        q <= hold;
    end
  end

  assign runt_blocker      = blk;
  assign dc_input_guard    = guard;
  assign out_copy_first.p  = q;
  assign out_copy_first.n  = ~q;
  assign out_copy_second.p = q;
  assign out_copy_second.n = ~q;

endmodule
`default_nettype wire

// ===== verif/gfcs_src_model.sv
// two redundant clock sources feeding the selector
`timescale 1ns/1ps
`default_nettype none
module gfcs_src_model #(
  parameter int HALF_A = 150,
  parameter int HALF_B = 225
) (
  // stop controls, high holds a source at dc
  input  wire logic stop_a,
  input  wire logic stop_b,
  // source clocks
  output logic      clock_in_first,
  output logic      clock_in_second
);
  // first source, frozen while stopped
  initial begin
    clock_in_first = 1'b0;
    forever #(HALF_A) if (!stop_a) clock_in_first = ~clock_in_first;
  end
  // second source, slower and unrelated
  initial begin
    clock_in_second = 1'b0;
    forever #(HALF_B) if (!stop_b) clock_in_second = ~clock_in_second;
  end
endmodule
`default_nettype wire

// ===== verif/gfcs_select_sva.sv
// assertions for the glitch-free clock selector
`timescale 1ns/1ps
`default_nettype none
module gfcs_select_sva (
  // system
  input wire logic                    clk,
  input wire logic                    sys_rst,
  // inputs
  input wire logic                    clock_in_first,
  input wire logic                    clock_in_second,
  input wire logic                    sel,
  input wire logic                    sel_undriven,
  input wire logic                    startup_init_pin,
  // outputs
  input wire logic                    runt_blocker,
  input wire logic                    dc_input_guard,
  input wire gfcs_pkg::gfcs_pair_type out_copy_first,
  input wire gfcs_pkg::gfcs_pair_type out_copy_second
);
  import gfcs_pkg::*;
  logic [7:0] run_len;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // cycles since the output last moved
  always_ff @(posedge clk) begin
    if (sys_rst || $changed(out_copy_first.p)) run_len <= 8'h00;
    else if (run_len != 8'hFF) run_len <= run_len + 8'h01;
  end
  a_copies_equal: assert property (
    out_copy_first == out_copy_second) else $error("output copies differ");
  a_pair_compl: assert property (
    out_copy_first.n == !out_copy_first.p) else $error("pair not complementary");
  a_bypass_mux: assert property (
    startup_init_pin [*4] |-> out_copy_first.p == ($past(sel | sel_undriven, 3) ?
    $past(clock_in_second, 3) : $past(clock_in_first, 3))) else $error("mux output wrong");
  a_bypass_noblk: assert property (
    startup_init_pin [*4] |-> !runt_blocker) else $error("blocker on in bypass");
  a_reset_quiet: assert property (disable iff (1'b0)
    sys_rst |=> !out_copy_first.p && !runt_blocker && !dc_input_guard)
    else $error("reset state wrong");
  a_init_hold: assert property (
    $fell(sys_rst) && !startup_init_pin |-> !out_copy_first.p [*8])
    else $error("output moved during init");
  a_guard_freeze: assert property (
    $rose(dc_input_guard) |-> $stable(out_copy_first) [*8]) else $error("dc output moved");
  a_no_runt: assert property (
    $changed(out_copy_first.p) && runt_blocker |-> run_len >= 8'h03)
    else $error("short output phase");
  // main scenarios
  cover property (runt_blocker && $changed(sel));
  cover property ($rose(dc_input_guard));
  cover property (startup_init_pin && $changed(out_copy_first.p));
endmodule
bind gfcs_select gfcs_select_sva i_gfcs_select_sva (.clk(clk), .sys_rst(sys_rst),
  .clock_in_first(clock_in_first), .clock_in_second(clock_in_second), .sel(sel),
  .sel_undriven(sel_undriven), .startup_init_pin(startup_init_pin),
  .runt_blocker(runt_blocker), .dc_input_guard(dc_input_guard),
  .out_copy_first(out_copy_first), .out_copy_second(out_copy_second));
`default_nettype wire

// ===== verif/gfcs_select_test.sv
// self-checking bench for the glitch-free clock selector
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module gfcs_select_test;
  import gfcs_pkg::*;
  logic          clk, sys_rst, sel, sel_undriven, startup_init_pin, stop_a, stop_b, pick;
  logic          clock_in_first, clock_in_second, runt_blocker, dc_input_guard;
  gfcs_pair_type out_copy_first, out_copy_second;
  logic [2:0]    hist;
  logic [2:0]    rows [4] = '{3'b000, 3'b101, 3'b011, 3'b111}; // sel, open, picks second
  int            failures, check_count, cyc;
  gfcs_src_model i_gfcs_src_model (.stop_a(stop_a), .stop_b(stop_b),
    .clock_in_first(clock_in_first), .clock_in_second(clock_in_second));
  gfcs_select i_gfcs_select (.clk(clk), .sys_rst(sys_rst), .clock_in_first(clock_in_first),
    .clock_in_second(clock_in_second), .sel(sel), .sel_undriven(sel_undriven),
    .startup_init_pin(startup_init_pin), .runt_blocker(runt_blocker),
    .dc_input_guard(dc_input_guard), .out_copy_first(out_copy_first),
    .out_copy_second(out_copy_second));
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    hist <= {hist[1:0], pick ? clock_in_second : clock_in_first};
    cyc++;
    if (cyc == 3000) begin failures++; test_done; end
  end
  task automatic test_done;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // bypass table, then suppressed switching and dead sources
  initial begin
    sys_rst = 1'b1; sel = 1'b0; sel_undriven = 1'b0; startup_init_pin = 1'b1;
    stop_a = 1'b0; stop_b = 1'b0; pick = 1'b0;
    cycles(4);
    `CHK("reset out", 2'b01, out_copy_first)
    sys_rst = 1'b0;
    foreach (rows[i]) begin
      {sel, sel_undriven, pick} = rows[i];
      cycles(4);
      repeat (30) begin cycles(1); `CHK("mux out", hist[2], out_copy_first.p) end
      `CHK("bypass blocker", 1'b0, runt_blocker)
    end
    sys_rst = 1'b1; startup_init_pin = 1'b0; sel = 1'b0; sel_undriven = 1'b0; pick = 1'b0;
    cycles(4);
    sys_rst = 1'b0;
    repeat (INIT_CYCLES) begin cycles(1); `CHK("init out", 1'b0, out_copy_first.p) end
    cycles(10);
    `CHK("blocker on", 1'b1, runt_blocker)
    for (int i = 0; i < 6; i++) begin sel = ~sel; cycles(37 + i * 5); end
    cycles(60);
    repeat (20) begin cycles(1); `CHK("follow", hist[2], out_copy_first.p) end
    stop_b = 1'b1;
    cycles(100);
    `CHK("idle unselected", 1'b0, dc_input_guard)
    stop_b = 1'b0; stop_a = 1'b1;
    cycles(100);
    `CHK("dc guard", 1'b1, dc_input_guard)
    // bypass back to suppression without reset: init must run again
    stop_a = 1'b0; startup_init_pin = 1'b1;
    cycles(20);
    @(negedge clock_in_first);
    cycles(1);
    startup_init_pin = 1'b0;
    cycles(1);
    repeat (INIT_CYCLES) begin cycles(1); `CHK("reinit out", 1'b0, out_copy_first.p) end
    test_done;
  end
endmodule
`default_nettype wire
